// ---- verilog/adc_run_ctrl.sv ----
// Run-state control with AXI4-Lite register access.
`timescale 1ns/1ps
module adc_run_ctrl
  import adc_run_pkg::*;
(
  input  wire logic      clk_in,
  input  wire logic      rst_n_in,
  input  wire axil_req_t axil_req_in,
  output wire axil_rsp_t axil_rsp_out,
  input  wire logic      restart_n_in,
  input  wire logic      hard_reset_n_in,
  input  wire logic      standby_n_in,
  input  wire logic      mod_bit_in,
  output wire logic      ready_n_out,
  output wire logic      powerdown_flag_out,
  output wire logic      mclk_out
);

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              aw_ok;
    logic [4:0]        aw_addr;
    logic              w_ok;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [2:0]        mode;
    logic [DATA_W-1:0] offset;
    logic [SET_W-1:0]  settle;
    logic [DATA_W-1:0] data;
    logic              ready_n;
    logic              settled_n;
    logic              pdown;
    logic              oneshot;
    logic              kick;
    logic              restart_prev;
  } ctl_state_t;

  ctl_state_t        q;
  ctl_state_t        d;
  logic [2:0]        pins_s;
  logic              restart_s;
  logic              hreset_s;
  logic              standby_s;
  logic              pd;
  logic              run;
  logic              f_hold;
  logic [DATA_W-1:0] f_sum;
  logic              f_done;
  logic [31:0]       wr_val;
  logic              wr_mode;

  // Loads register defaults; bus handshake fields are left alone.
  function automatic ctl_state_t apply_defaults(input ctl_state_t s);
    ctl_state_t r;
    r           = s;
    r.mode      = MODE_RST;
    r.offset    = OFFSET_RST;
    r.settle    = SETTLE_RST;
    r.data      = '0;
    r.ready_n   = 1'b1;
    r.settled_n = 1'b1;
    r.oneshot   = 1'b0;
    r.kick      = 1'b0;
    return r;
  endfunction : apply_defaults

  // True for every decoded register address.
  function automatic logic is_mapped(input logic [4:0] a);
    return a == REG_MODE || a == REG_STATUS || a == REG_DATA ||
           a == REG_OFFSET || a == REG_SETTLE;
  endfunction : is_mapped

  // Read view of a register; unused bits read as zero.
  function automatic logic [31:0] rd_mux(input ctl_state_t s,
                                         input logic [4:0] a);
    logic [31:0] v;
    v = '0;
    unique case (a)
      REG_MODE: v[2:0] = s.mode;
      REG_STATUS: begin
        v[ST_READY]          = s.ready_n;
        v[ST_SETTLED]        = s.settled_n;
        v[ST_PDOWN]          = s.pdown;
        v[ST_MODE+2:ST_MODE] = s.mode;
      end
      REG_DATA: v[DATA_W-1:0] = s.data;
      REG_OFFSET: v[DATA_W-1:0] = s.offset;
      REG_SETTLE: v[SET_W-1:0] = s.settle;
      default: v = '0;
    endcase
    return v;
  endfunction : rd_mux

  // Applies byte enables over the old register contents.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // control pins pass the synchroniser before any use.
  pin_sync u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .pins_in  ({standby_n_in, hard_reset_n_in, restart_n_in}),
    .pins_out (pins_s)
  );

  assign restart_s = pins_s[0];
  assign hreset_s  = pins_s[1];
  assign standby_s = pins_s[2];

  // standby by pin or by mode code.
  assign pd = !standby_s || (q.mode == MODE_STANDBY);

  // idle runs nothing unless a restart one-shot is pending.
  assign run = !pd && hreset_s && restart_s &&
               (q.mode == MODE_CONT || q.mode == MODE_SINGLE || q.oneshot);

  // filter held while restart is low, released on next edge.
  assign f_hold = !run || q.kick;

  decim_filter u_filt (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .hold_in    (f_hold),
    .mod_bit_in (mod_bit_in),
    .settle_in  (q.settle),
    .sum_out    (f_sum),
    .done_out   (f_done)
  );

  // Next-state logic for the bus slave and the run control.
  always_comb begin
    d              = q;
    d.kick         = 1'b0;
    d.restart_prev = restart_s;
    d.pdown        = pd;
    wr_val         = '0;
    wr_mode        = 1'b0;
    if (axil_req_in.awvalid && q.awready) begin
      d.aw_ok   = 1'b1;
      d.aw_addr = axil_req_in.awaddr;
    end
    if (axil_req_in.wvalid && q.wready) begin
      d.w_ok   = 1'b1;
      d.w_data = axil_req_in.wdata;
      d.w_strb = axil_req_in.wstrb;
    end
    if (axil_req_in.bready && q.bvalid) begin
      d.bvalid = 1'b0;
    end
    if (axil_req_in.rready && q.rvalid) begin
      d.rvalid = 1'b0;
    end
    // restart falling edge drops the settled state.
    if (q.restart_prev && !restart_s) begin
      d.settled_n = 1'b1;
      d.oneshot   = 1'b0;
    end
    // restart rising edge in idle starts one conversion.
    if (!q.restart_prev && restart_s && q.mode == MODE_IDLE) begin
      d.oneshot = 1'b1;
      d.ready_n = 1'b1;
    end
    // reads are served in every mode, standby included.
    if (axil_req_in.arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_mux(q, axil_req_in.araddr);
      d.rresp  = is_mapped(axil_req_in.araddr) ? RESP_OKAY : RESP_SLVERR;
      if (!hreset_s) begin
        d.rdata = '0;
        d.rresp = RESP_SLVERR;
      end else if (axil_req_in.araddr == REG_DATA) begin
        d.ready_n = 1'b1;
      end
    end
    // a settled result drives ready low.
    // a finished single conversion falls back to idle.
    // A result still in flight when a mode write restarts the filter is
    // dropped, so the first result after the write covers a full window.
    if (f_done && run && !q.kick) begin
      d.data      = f_sum - q.offset;
      d.ready_n   = 1'b0;
      d.settled_n = 1'b0;
      d.oneshot   = 1'b0;
      if (q.mode == MODE_SINGLE) begin
        d.mode = MODE_IDLE;
      end
    end
    // Writes complete once both address and data are held.
    if (d.aw_ok && d.w_ok && !d.bvalid) begin
      d.aw_ok  = 1'b0;
      d.w_ok   = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      wr_val   = merge(rd_mux(q, d.aw_addr), d.w_data, d.w_strb);
      // writes are dropped while the hard reset pin is low.
      if (!hreset_s) begin
        d.bresp = RESP_SLVERR;
      end else if (!is_mapped(d.aw_addr)) begin
        d.bresp = RESP_SLVERR;
      end else if (d.aw_addr == REG_MODE) begin
        d.mode    = wr_val[2:0];
        d.kick    = 1'b1;
        d.ready_n = 1'b1;
        wr_mode   = 1'b1;
      end else if (d.aw_addr == REG_OFFSET) begin
        d.offset = wr_val[DATA_W-1:0];
      end else if (d.aw_addr == REG_SETTLE) begin
        d.settle = wr_val[SET_W-1:0];
      end
    end
    d.awready = !d.aw_ok && !d.bvalid;
    d.wready  = !d.w_ok && !d.bvalid;
    d.arready = !d.rvalid;
    // standby forces ready and settled high.
    if (pd) begin
      d.ready_n   = 1'b1;
      d.settled_n = 1'b1;
    end
    // hard reset returns every register to its default.
    if (!hreset_s) begin
      d = apply_defaults(d);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      // The restart edge detector starts at the pin's idle level.
      q <= apply_defaults('{restart_prev: 1'b1, default: '0});
    end else begin
      q <= d;
    end
  end

  assign axil_rsp_out.awready = q.awready;
  assign axil_rsp_out.wready  = q.wready;
  assign axil_rsp_out.bresp   = q.bresp;
  assign axil_rsp_out.bvalid  = q.bvalid;
  assign axil_rsp_out.arready = q.arready;
  assign axil_rsp_out.rdata   = q.rdata;
  assign axil_rsp_out.rresp   = q.rresp;
  assign axil_rsp_out.rvalid  = q.rvalid;
  assign ready_n_out          = q.ready_n;
  // standby flag is registered for pin and status.
  assign powerdown_flag_out   = q.pdown;

  // master clock forwarded; it never stops in reset or standby.
  assign mclk_out = clk_in;

  chk_ready_in_reset: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !hreset_s |=> (ready_n_out && q.settled_n))
    else $error("Ready not held high during hard reset.");

  chk_reset_defaults: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !hreset_s |=> (q.mode == MODE_RST && q.offset == OFFSET_RST &&
                   q.settle == SETTLE_RST && q.data == '0))
    else $error("Registers not at defaults after hard reset.");

  chk_standby_flags: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    pd |=> (ready_n_out && q.settled_n && powerdown_flag_out))
    else $error("Standby did not raise ready and settled.");

  chk_standby_entry: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    $fell(standby_n_in) |-> ##3 powerdown_flag_out)
    else $error("Standby pin did not enter power-down in time.");

  chk_single_idle: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (f_done && run && q.mode == MODE_SINGLE && !wr_mode && hreset_s &&
     !q.kick) |=> (q.mode == MODE_IDLE && !ready_n_out))
    else $error("Single conversion did not return to idle.");

  chk_done_ready: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (f_done && run && hreset_s && !q.kick && !wr_mode) |=>
      (!ready_n_out && !q.settled_n &&
       q.data == $past(f_sum - q.offset)))
    else $error("Result did not update data and ready.");

  chk_restart_hold: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !restart_s |-> (f_hold ##1 !f_done))
    else $error("Filter not held while restart is low.");

  chk_restart_resume: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ($rose(restart_s) && !pd && hreset_s && !q.kick &&
     q.mode == MODE_CONT) |-> !f_hold)
    else $error("Filter not released after restart rise.");

  chk_oneshot_start: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ($rose(restart_s) && q.mode == MODE_IDLE && hreset_s && !pd)
      |=> (q.oneshot && ready_n_out))
    else $error("Restart rise in idle did not start conversion.");

  chk_standby_retain: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (pd && hreset_s) |=> (q.data == $past(q.data)))
    else $error("Data register changed during standby.");

  chk_wake_flags: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    $fell(pd) |=> (ready_n_out && q.settled_n))
    else $error("Ready or settled fell right after standby ended.");

  chk_idle_quiet: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (q.mode == MODE_IDLE && !q.oneshot) |-> (f_hold ##1 !f_done))
    else $error("Idle mode ran the filter.");

  chk_write_refused: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (!hreset_s && d.bvalid && !q.bvalid) |=>
      (axil_rsp_out.bvalid && axil_rsp_out.bresp == RESP_SLVERR))
    else $error("Write during hard reset was not refused.");

  chk_read_refused: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (!hreset_s && axil_req_in.arvalid && q.arready) |=>
      (axil_rsp_out.rresp == RESP_SLVERR && axil_rsp_out.rdata == '0))
    else $error("Read during hard reset was not refused.");

endmodule : adc_run_ctrl

// ---- verilog/adc_run_pkg.sv ----
// Shared constants and types for the converter run-state control.
package adc_run_pkg;

  localparam int          SYNC_W       = 3;
  localparam int          DATA_W       = 24;
  localparam int          SET_W        = 16;
  localparam logic [4:0]  MOD_DIV_LAST = 5'h1F;
  localparam logic [4:0]  REG_MODE     = 5'h00;
  localparam logic [4:0]  REG_STATUS   = 5'h04;
  localparam logic [4:0]  REG_DATA     = 5'h08;
  localparam logic [4:0]  REG_OFFSET   = 5'h0C;
  localparam logic [4:0]  REG_SETTLE   = 5'h10;
  localparam logic [23:0] OFFSET_RST   = 24'h000000;
  localparam logic [15:0] SETTLE_RST   = 16'h0040;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam int          ST_READY     = 0;
  localparam int          ST_SETTLED   = 1;
  localparam int          ST_PDOWN     = 2;
  localparam int          ST_MODE      = 4;

  typedef enum logic [2:0] {
    MODE_IDLE    = 3'h0,
    MODE_CONT    = 3'h1,
    MODE_SINGLE  = 3'h2,
    MODE_STANDBY = 3'h3
  } op_mode_t;

  localparam op_mode_t MODE_RST = MODE_CONT;

  typedef struct packed {
    logic [4:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [4:0]  araddr;
    logic        arvalid;
    logic        rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axil_rsp_t;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
  } sync_state_t;

  typedef struct packed {
    logic [4:0]        div;
    logic [SET_W-1:0]  tick;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] sum;
    logic              done;
  } filt_state_t;

endpackage : adc_run_pkg

// ---- verilog/pin_sync.sv ----
// Two-stage synchroniser for the asynchronous control pins.
`timescale 1ns/1ps
module pin_sync
  import adc_run_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic [SYNC_W-1:0] pins_in,
  output wire logic [SYNC_W-1:0] pins_out
);

  sync_state_t q;
  sync_state_t d;

  always_comb begin
    d    = q;
    d.s1 = pins_in;
    d.s2 = q.s1;
  end

  // All lines idle high, so reset fills both stages with ones.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign pins_out = q.s2;

  chk_sync_delay: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |-> ##2 (pins_out == $past(pins_in, 2)))
    else $error("Synchroniser delay is not two clocks.");

endmodule : pin_sync

// ---- verilog/decim_filter.sv ----
// Modulator tick divider and accumulating decimation filter.
`timescale 1ns/1ps
module decim_filter
  import adc_run_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              hold_in,
  input  wire logic              mod_bit_in,
  input  wire logic [SET_W-1:0]  settle_in,
  output wire logic [DATA_W-1:0] sum_out,
  output wire logic              done_out
);

  filt_state_t q;
  filt_state_t d;

  // ticks derive from the master clock, so rates scale with it.
  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (hold_in) begin
      d.div  = '0;
      d.tick = '0;
      d.acc  = '0;
    end else begin
      d.div = q.div + 5'h01;
      if (q.div == MOD_DIV_LAST) begin
        d.acc  = q.acc + DATA_W'(mod_bit_in);
        d.tick = q.tick + 16'h0001;
        if (32'(q.tick) + 1 >= 32'(settle_in)) begin
          d.sum  = d.acc;
          d.done = 1'b1;
          d.acc  = '0;
          d.tick = '0;
        end
      end
    end
  end

  // Registers the filter state.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sum_out  = q.sum;
  assign done_out = q.done;

  chk_hold_clear: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    hold_in |=> (!done_out && q.acc == '0 && q.div == '0))
    else $error("Filter not cleared while held.");

endmodule : decim_filter

// ---- verif/host_pin_model.sv ----
// Host model that drives the control pins and the modulator bitstream.
`timescale 1ns/1ps
module host_pin_model (
  input  wire logic clk_in,
  output logic      restart_n_out,
  output logic      hard_reset_n_out,
  output logic      standby_n_out,
  output logic      mod_bit_out
);
  // pins idle
  // Pins stay inactive from time zero, so the bench can configure first.
  initial begin
    restart_n_out    = 1'b1;
    hard_reset_n_out = 1'b1;
    standby_n_out    = 1'b1;
    mod_bit_out      = 1'b1;
  end

  // shared restart
  // Restart is only applied after the bench has written the configuration.
  task set_restart(input logic v);
    restart_n_out <= v;
  endtask : set_restart

  task pulse_restart(input int n);
    restart_n_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    restart_n_out <= 1'b1;
  endtask : pulse_restart

  task set_standby(input logic v);
    standby_n_out <= v;
  endtask : set_standby

  // Modulator output level; a run of zeros gives an all-zero count.
  task set_mod(input logic v);
    mod_bit_out <= v;
  endtask : set_mod

  // reconfigure after reset
  // The bench rewrites the settling count once this pin returns high.
  task set_hard(input logic v);
    hard_reset_n_out <= v;
  endtask : set_hard
endmodule : host_pin_model

// ---- verif/tb.sv ----
// Self-checking bench for the converter run-state control.
`timescale 1ns/1ps
module tb;
  import adc_run_pkg::*;
  localparam int NS  = 2;
  localparam int LIM = 10000;
  typedef struct {
    string       nm;
    logic [31:0] d;
    logic [1:0]  r;
  } exp_t;
  logic        clk_in;
  logic        rst_n_in;
  axil_req_t   req;
  axil_rsp_t   rsp;
  logic        restart_n, hard_n, powerdown_flag_n, mod_bit;
  logic        ready_n, pdown, mclk;
  int          n_mismatch;
  int          tests_run;
  int          cyc;
  integer      seed;
  logic [23:0] off;
  logic [3:0]  strb;
  exp_t        e;
  exp_t        rq[$];
  logic [1:0]  bq[$];

  adc_run_ctrl uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .axil_req_in(req), .axil_rsp_out(rsp), .restart_n_in(restart_n),
    .hard_reset_n_in(hard_n), .standby_n_in(powerdown_flag_n), .mod_bit_in(mod_bit),
    .ready_n_out(ready_n), .powerdown_flag_out(pdown), .mclk_out(mclk));

  host_pin_model u_host (.clk_in(clk_in), .restart_n_out(restart_n),
    .hard_reset_n_out(hard_n), .standby_n_out(powerdown_flag_n),
    .mod_bit_out(mod_bit));

  // Free-running master clock at 10 MHz.
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task final_report();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      $display("mismatch %s exp %0h got %0h", nm, x, g);
      n_mismatch++;
    end
  endtask : cmp

  // Responses are matched against the oldest note; the watchdog ends hangs.
  always @(posedge clk_in) begin
    cyc++;
    if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
      e = rq.pop_front();
      cmp({e.nm, " data"}, e.d, rsp.rdata);
      cmp({e.nm, " rresp"}, {30'h0, e.r}, {30'h0, rsp.rresp});
    end
    if (rsp.bvalid === 1'b1 && req.bready === 1'b1) begin
      cmp("bresp", {30'h0, bq.pop_front()}, {30'h0, rsp.bresp});
    end
    if (cyc > LIM) begin
      n_mismatch++;
      final_report();
    end
  end

  // Write: address and data offered together, each released when taken.
  task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_ok, w_ok;
    bq.push_back(r);
    aw_ok = 1'b0;
    w_ok = 1'b0;
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= strb;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_in);
      if (!aw_ok && rsp.awready === 1'b1) begin
        aw_ok = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w_ok && rsp.wready === 1'b1) begin
        w_ok = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge clk_in); while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    @(posedge clk_in);
  endtask : wr

  task rd(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r,
          input string nm);
    rq.push_back('{nm, d, r});
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do @(posedge clk_in); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk_in); while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    @(posedge clk_in);
  endtask : rd

  // Counts cycles until ready falls and checks the count lies in a window.
  task wait_rdy(input int lo, input int hi, input string nm);
    int n;
    n = 0;
    while (ready_n !== 1'b0 && n <= hi) begin
      @(posedge clk_in);
      n++;
    end
    tests_run++;
    if (n < lo || n > hi) begin
      $display("mismatch %s exp %0d..%0d got %0d", nm, lo, hi, n);
      n_mismatch++;
    end
  endtask : wait_rdy

  task chk_mclk();
    @(negedge clk_in);
    #1 cmp("mclk low", 32'h0, {31'h0, mclk});
    @(posedge clk_in);
    #1 cmp("mclk high", 32'h1, {31'h0, mclk});
    @(posedge clk_in);
  endtask : chk_mclk

  // Main sequence: defaults, conversions, restart, standby, hard reset.
  initial begin
    seed = 32'h1A84723F;
    strb = 4'hF;
    n_mismatch = 0;
    tests_run = 0;
    cyc = 0;
    req = '0;
    rst_n_in = 1'b0;
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rd(REG_MODE, 32'h1, RESP_OKAY, "mode rst");
    rd(REG_OFFSET, 32'h0, RESP_OKAY, "offset rst");
    rd(REG_SETTLE, 32'h40, RESP_OKAY, "settle rst");
    rd(5'h14, 32'h0, RESP_SLVERR, "unmapped");
    off = 24'($random(seed));
    wr(REG_SETTLE, NS, RESP_OKAY);
    wr(REG_OFFSET, {8'h0, off}, RESP_OKAY);
    rd(REG_OFFSET, {8'h0, off}, RESP_OKAY, "offset rw");
    // Only byte lane 1 is enabled, so only that byte of the offset clears.
    strb = 4'h2;
    wr(REG_OFFSET, 32'h0, RESP_OKAY);
    strb = 4'hF;
    off[15:8] = 8'h00;
    rd(REG_OFFSET, {8'h0, off}, RESP_OKAY, "offset strb");
    wr(REG_MODE, 32'h1, RESP_OKAY);
    wait_rdy(32 * (NS - 1), 32 * NS + 12, "conv time");
    rd(REG_DATA, {8'h0, 24'(NS) - off}, RESP_OKAY, "data");
    wr(REG_MODE, 32'h2, RESP_OKAY);
    wait_rdy(32 * (NS - 1), 32 * NS + 12, "single");
    rd(REG_STATUS, 32'h0, RESP_OKAY, "single idle");
    rd(REG_DATA, {8'h0, 24'(NS) - off}, RESP_OKAY, "single data");
    repeat (96 * NS) @(posedge clk_in);
    cmp("idle ready", 32'h1, {31'h0, ready_n});
    u_host.set_mod(1'b0);
    u_host.pulse_restart(3);
    wait_rdy(32 * (NS - 1), 32 * NS + 12, "restart shot");
    rd(REG_DATA, {8'h0, 24'h0 - off}, RESP_OKAY, "shot data");
    u_host.set_mod(1'b1);
    wr(REG_MODE, 32'h1, RESP_OKAY);
    u_host.set_restart(1'b0);
    repeat (200) @(posedge clk_in);
    cmp("held ready", 32'h1, {31'h0, ready_n});
    u_host.set_restart(1'b1);
    wait_rdy(32 * (NS - 1), 32 * NS + 12, "resume");
    rd(REG_SETTLE, NS, RESP_OKAY, "settle kept");
    u_host.set_standby(1'b0);
    repeat (4) @(posedge clk_in);
    cmp("pdown pin", 32'h1, {31'h0, pdown});
    cmp("powerdown_flag ready", 32'h1, {31'h0, ready_n});
    rd(REG_STATUS, 32'h17, RESP_OKAY, "powerdown_flag status");
    rd(REG_DATA, {8'h0, 24'(NS) - off}, RESP_OKAY, "powerdown_flag data");
    chk_mclk();
    u_host.set_standby(1'b1);
    repeat (4) @(posedge clk_in);
    cmp("wake pdown", 32'h0, {31'h0, pdown});
    cmp("wake ready", 32'h1, {31'h0, ready_n});
    wait_rdy(32 * (NS - 1), 32 * NS + 12, "wake conv");
    wr(REG_MODE, 32'h3, RESP_OKAY);
    repeat (2) @(posedge clk_in);
    cmp("pdown mode", 32'h1, {31'h0, pdown});
    rd(REG_STATUS, 32'h37, RESP_OKAY, "mode powerdown_flag");
    u_host.set_hard(1'b0);
    repeat (4) @(posedge clk_in);
    cmp("hard ready", 32'h1, {31'h0, ready_n});
    rd(REG_MODE, 32'h0, RESP_SLVERR, "hard read");
    wr(REG_SETTLE, 32'h5, RESP_SLVERR);
    chk_mclk();
    u_host.set_hard(1'b1);
    wait_rdy(32 * 63, 32 * 64 + 12, "hard conv");
    rd(REG_MODE, 32'h1, RESP_OKAY, "hard mode");
    rd(REG_SETTLE, 32'h40, RESP_OKAY, "hard settle");
    rd(REG_OFFSET, 32'h0, RESP_OKAY, "hard offset");
    wr(REG_SETTLE, NS, RESP_OKAY);
    final_report();
  end
endmodule : tb
